// >>> crs_pkg.sv
// Shared constants and types for the converter reset and initialisation sequencer
package crs_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_MHZ          = 200;       // Sampling clock rate
    localparam int unsigned CAL_CYCLES       = 200000;    // Power-up calibration length
    localparam int unsigned FUSE_LOAD_CYCLES = 8;         // Default load from fuse storage
    localparam int unsigned CNT_W            = 18;        // Wide enough for 200000

    // ------------------------------------------------------------------
    // Serial frame layout: rw flag, 15-bit address, 8-bit data
    // ------------------------------------------------------------------
    localparam int unsigned FRAME_BITS = 24;
    localparam int unsigned ADDR_BITS  = 16;              // Bits before data phase
    localparam logic [4:0]  FRAME_LAST = 5'h17;           // Index of the last bit
    localparam logic [4:0]  ADDR_LAST  = 5'h0f;           // Index of the last address bit

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [14:0] SOFTWARE_RESET_CONTROL_OFS = 15'h0000;
    localparam logic [14:0] INIT_STATUS_OFS            = 15'h0001;
    localparam int unsigned SW_RESET_BIT               = 0;
    localparam logic [7:0]  SOFTWARE_RESET_CONTROL_RST = 8'h00;
    localparam logic [7:0]  UNMAPPED_READ              = 8'h00;

    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CRS_HOLD,
        CRS_LOAD,
        CRS_CAL,
        CRS_READY
    } crs_state_t;

    // Status word seen by the host
    typedef struct packed {
        logic [4:0] zero;       // Reads as zero
        logic       ref_sel;    // Reference-select level caught at reset release
        logic       loaded;     // Defaults loaded from fuse storage
        logic       cal_done;   // Power-up calibration finished
    } crs_status_t;

endpackage : crs_pkg

// >>> crs_init_sequencer.sv
// Reset, default load and power-up calibration sequencer with its serial register port
`timescale 1ns/100ps
// Overview of operation
// - Reset release loads fuse defaults, starts calibration
// - Calibration lasts 200000 sampling-clock cycles
// - Writing one to bit 0 resets registers
// - Software reset bit clears itself
// - Both resets need 200000-cycle wait
module crs_init_sequencer
    import crs_pkg::*;
#(
    parameter int unsigned CAL_LEN = CAL_CYCLES      // Calibration length in cycles
)(
    input  wire logic mclk_i,                        // Sampling clock
    input  wire logic rst_n_i,                       // Power-on reset, active low
    input  wire logic hw_reset_i,                    // Hardware reset pin, active high
    input  wire logic reference_select_pin_i,        // Reference-select pin
    input  wire logic serial_port_chip_select_n_i,   // Serial chip select, active low
    input  wire logic serial_clk_i,                  // Serial clock
    input  wire logic serial_data_i,                 // Serial data in
    output logic      serial_data_o,                 // Serial data out
    output logic      serial_data_oe_o,              // Serial data out drive enable
    output logic      init_busy_o,                   // Load or calibration in progress
    output logic      cal_done_o                     // Calibration complete
);

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic [1:0] rst_pin_s;       // Reset pin stages
    logic [1:0] ref_s;           // Reference pin stages
    logic [1:0] cs_s;            // Chip select stages
    logic [2:0] sck_s;           // Serial clock stages plus edge history
    logic [1:0] sdi_s;           // Serial data stages

    // Two flops per pin, three for serial clock; second stage feeds logic, clock edges also use the third
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_pin_s <= 2'h0;
            ref_s     <= 2'h0;
            cs_s      <= 2'h3;
            sck_s     <= 3'h0;
            sdi_s     <= 2'h0;
        end
        else
        begin
            rst_pin_s <= {rst_pin_s[0], hw_reset_i};
            ref_s     <= {ref_s[0], reference_select_pin_i};
            cs_s      <= {cs_s[0], serial_port_chip_select_n_i};
            sck_s     <= {sck_s[1:0], serial_clk_i};
            sdi_s     <= {sdi_s[0], serial_data_i};
        end
    end

    wire rst_pin   = rst_pin_s[1];                 // Synchronised reset pin
    wire cs_act    = !cs_s[1];                     // Frame in progress
    wire sck_rise  = sck_s[1] && !sck_s[2];        // Sample edge
    wire sck_fall  = !sck_s[1] && sck_s[2];        // Launch edge

    // ------------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------------
    crs_state_t       state_q;
    crs_state_t       state_d;
    logic [CNT_W-1:0] cnt_q;          // Cycles spent in load or calibration
    logic [CNT_W-1:0] cnt_d;
    logic             swrst_q;        // Software reset bit
    logic             swrst_d;
    logic             ref_sel_q;      // Reference level caught at release
    logic             loaded_q;       // Defaults present

    // Serial port state
    logic [4:0]       bit_q;          // Bit index within the frame
    logic [22:0]      shin_q;         // Received bits
    logic [7:0]       shout_q;        // Read data being shifted out
    logic             rd_q;           // Current frame is a read
    logic             sdo_q;          // Serial data out flop
    logic             sdo_oe_q;       // Serial data out enable flop
    logic             busy_q;         // Registered busy output
    logic             done_q;         // Registered calibration done output

    // Frame decode
    wire         last_bit  = cs_act && sck_rise && (bit_q == FRAME_LAST);
    wire         addr_done = cs_act && sck_rise && (bit_q == ADDR_LAST);
    wire         wr_commit = last_bit && !rd_q;
    wire [7:0]   wr_data   = {shin_q[6:0], sdi_s[1]};
    wire [14:0]  wr_addr   = shin_q[21:7];                      // Address sits below rw flag
    wire         ctl_hit   = wr_commit && (wr_addr == SOFTWARE_RESET_CONTROL_OFS);
    wire         sw_req    = ctl_hit && wr_data[SW_RESET_BIT];
    wire         cal_end   = (cnt_q == CAL_LEN[CNT_W-1:0] - 18'h00001);
    wire         load_end  = (cnt_q == FUSE_LOAD_CYCLES[CNT_W-1:0] - 18'h00001);

    // Readback mux
    crs_status_t status;
    assign status.zero     = 5'h00;
    assign status.ref_sel  = ref_sel_q;
    assign status.loaded   = loaded_q;
    assign status.cal_done = (state_q == CRS_READY);

    wire [14:0] rd_addr   = {shin_q[13:0], sdi_s[1]};
    wire        rd_flag   = shin_q[14];
    wire [7:0]  rd_ctl    = {7'h00, swrst_q};
    wire [7:0]  rd_data   = (rd_addr == SOFTWARE_RESET_CONTROL_OFS) ? rd_ctl :
                            (rd_addr == INIT_STATUS_OFS)            ? status :
                                                                      UNMAPPED_READ;

    // ------------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------------
    // Pin reset holds everything; release or software reset starts a fresh load
    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q + 18'h00001;
        swrst_d = swrst_q;
        case (state_q)
            CRS_HOLD:
            begin
                cnt_d = '0;
                if (!rst_pin)
                    state_d = CRS_LOAD;
            end
            CRS_LOAD:
            begin
                // Fuse defaults being restored
                if (load_end)
                begin
                    state_d = CRS_CAL;
                    cnt_d   = '0;
                end
            end
            CRS_CAL:
            begin
                if (cal_end)
                    state_d = CRS_READY;
            end
            CRS_READY:
            begin
                cnt_d = cnt_q;                      // Counter parked
            end
            default:
            begin
                state_d = CRS_HOLD;
            end
        endcase
        // Bit seen set: restart the load, even mid-load, and drop the bit
        if (swrst_q)
        begin
            state_d = CRS_LOAD;
            cnt_d   = '0;
            swrst_d = 1'b0;
        end
        // A write landing in the clearing cycle keeps the bit set
        if (sw_req)
            swrst_d = 1'b1;
        // Reset pin wins over everything
        if (rst_pin)
        begin
            state_d = CRS_HOLD;
            cnt_d   = '0;
            swrst_d = SOFTWARE_RESET_CONTROL_RST[SW_RESET_BIT];
        end
    end

    // Sequencer registers
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_q <= CRS_HOLD;
            cnt_q   <= '0;
            swrst_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            swrst_q <= swrst_d;
        end
    end

    // Reference level caught at pin release; load flag tracks fuse copy
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ref_sel_q <= 1'b0;
            loaded_q  <= 1'b0;
        end
        else
        begin
            if (state_q == CRS_HOLD && !rst_pin)
                ref_sel_q <= ref_s[1];
            if (state_q == CRS_LOAD && load_end)
                loaded_q <= 1'b1;
            else if (state_q == CRS_HOLD || state_d == CRS_LOAD)
                loaded_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Serial receive and transmit
    // ------------------------------------------------------------------
    // Bits taken on serial clock rise, read data launched on fall
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            bit_q    <= 5'h00;
            shin_q   <= 23'h000000;
            shout_q  <= 8'h00;
            rd_q     <= 1'b0;
            sdo_q    <= 1'b0;
            sdo_oe_q <= 1'b0;
        end
        else if (!cs_act)
        begin
            bit_q    <= 5'h00;                      // Idle between frames
            rd_q     <= 1'b0;
            sdo_oe_q <= 1'b0;
        end
        else
        begin
            if (sck_rise)
            begin
                shin_q <= {shin_q[21:0], sdi_s[1]};
                bit_q  <= last_bit ? 5'h00 : bit_q + 5'h01;
                if (addr_done)
                begin
                    rd_q    <= rd_flag;
                    shout_q <= rd_data;
                end
            end
            if (sck_fall && rd_q)
            begin
                sdo_oe_q <= 1'b1;
                sdo_q    <= shout_q[7];
                shout_q  <= {shout_q[6:0], 1'b0};
            end
        end
    end

    // Registered status outputs
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            busy_q <= (state_d == CRS_LOAD) || (state_d == CRS_CAL);
            done_q <= (state_d == CRS_READY);
        end
    end

    assign serial_data_o    = sdo_q;
    assign serial_data_oe_o = sdo_oe_q;
    assign init_busy_o      = busy_q;
    assign cal_done_o       = done_q;

endmodule : crs_init_sequencer

// >>> crs_init_checker.sv
// Assertions on the ports of the reset and calibration sequencer
`timescale 1ns/100ps
module crs_init_checker
    import crs_pkg::*;
#(
    parameter int unsigned CAL_LEN = CAL_CYCLES  // Calibration length in cycles
)(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic hw_reset_i,
    input wire logic reference_select_pin_i,
    input wire logic serial_port_chip_select_n_i,
    input wire logic serial_clk_i,
    input wire logic serial_data_i,
    input wire logic serial_data_o,
    input wire logic serial_data_oe_o,
    input wire logic init_busy_o,
    input wire logic cal_done_o
);
    localparam int LEN_LO = CAL_LEN + FUSE_LOAD_CYCLES - 2;  // Shortest busy stretch
    localparam int LEN_HI = CAL_LEN + FUSE_LOAD_CYCLES + 2;  // Longest busy stretch
    logic [CNT_W-1:0] busy_cnt_q;                            // Cycles of the current busy run
    logic [CNT_W-1:0] busy_cnt_d;
    assign busy_cnt_d = init_busy_o ? busy_cnt_q + 1'b1 : '0;
    // Busy run counter, cleared whenever busy drops
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            busy_cnt_q <= '0;
        else
            busy_cnt_q <= busy_cnt_d;
    end
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_pin_held;
        hw_reset_i [*6];
    endsequence
    sequence s_cs_idle;
        serial_port_chip_select_n_i [*6];
    endsequence
    a_busy_done_excl: assert property (!(init_busy_o && cal_done_o))
        else $error("busy and done high together");
    a_pin_clears_all: assert property (s_pin_held |-> !init_busy_o && !cal_done_o)
        else $error("reset pin did not stop the sequence");
    a_release_starts_busy: assert property ($fell(hw_reset_i) |-> ##[2:6] init_busy_o)
        else $error("no load after reset pin release");
    a_done_after_busy: assert property ($rose(cal_done_o) |-> $past(init_busy_o))
        else $error("done rose without a busy phase");
    a_cal_length_ok: assert property ($rose(cal_done_o) |->
        busy_cnt_q >= LEN_LO && busy_cnt_q <= LEN_HI)
        else $error("calibration length wrong");
    a_busy_run_bounded: assert property (busy_cnt_q <= LEN_HI)
        else $error("busy lasted too long");
    a_oe_idle_cs: assert property (s_cs_idle |-> !serial_data_oe_o)
        else $error("read data driven without chip select");
    a_done_holds_idle: assert property (cal_done_o && !hw_reset_i
        && serial_port_chip_select_n_i |=> cal_done_o)
        else $error("done dropped without a reset");
endmodule : crs_init_checker

bind crs_init_sequencer crs_init_checker #(.CAL_LEN(CAL_LEN)) i_checker (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .hw_reset_i(hw_reset_i),
    .reference_select_pin_i(reference_select_pin_i),
    .serial_port_chip_select_n_i(serial_port_chip_select_n_i),
    .serial_clk_i(serial_clk_i), .serial_data_i(serial_data_i),
    .serial_data_o(serial_data_o), .serial_data_oe_o(serial_data_oe_o),
    .init_busy_o(init_busy_o), .cal_done_o(cal_done_o));

// >>> crs_host_model.sv
// Host controller model driving the reset pin, reference pin and serial port
`timescale 1ns/100ps
module crs_host_model #(
    parameter int unsigned PWR_DLY = 400000,  // Cycles from pin_reset start to reference level
    parameter int unsigned HP      = 6        // Serial clock half period in cycles
)(
    input  wire logic mclk_i,
    input  wire logic sdo_i,
    output logic      hw_reset_o,
    output logic      ref_sel_o,
    output logic      cs_n_o,
    output logic      sclk_o,
    output logic      sdi_o
);
    // Idle levels at power-up
    initial
    begin
        hw_reset_o = 1'b0;
        ref_sel_o  = 1'b0;
        cs_n_o     = 1'b1;
        sclk_o     = 1'b0;
        sdi_o      = 1'b0;
    end
    // Reference level, settle time, then a 1 us high pulse on the reset pin
    task automatic pin_reset(input logic lvl);
        repeat (PWR_DLY) @(posedge mclk_i);
        ref_sel_o <= lvl;
        repeat (20) @(posedge mclk_i);
        hw_reset_o <= 1'b1;
        repeat (200) @(posedge mclk_i);
        hw_reset_o <= 1'b0;
    endtask : pin_reset
    // One 24-bit frame; read data is caught at the end of each of the last eight low phases
    task automatic frame(input logic rw, input logic [14:0] addr,
                         input logic [7:0] wd, output logic [7:0] rd);
        logic [23:0] w;
        w  = {rw, addr, wd};
        rd = 8'h00;
        @(posedge mclk_i);
        cs_n_o <= 1'b0;
        for (int i = 23; i >= 0; i--)
        begin
            sdi_o <= w[i];
            repeat (HP) @(posedge mclk_i);
            if (i < 8)
                rd[i] = sdo_i;
            sclk_o <= 1'b1;
            repeat (HP) @(posedge mclk_i);
            sclk_o <= 1'b0;
        end
        repeat (HP) @(posedge mclk_i);
        cs_n_o <= 1'b1;
        sdi_o  <= ~w[0];                     // Released line shows no stale bit
        repeat (HP) @(posedge mclk_i);
    endtask : frame
endmodule : crs_host_model

// >>> crs_init_sequencer_test.sv
// Self-checking bench for the reset and calibration sequencer
`timescale 1ns/100ps
module crs_init_sequencer_test;
    import crs_pkg::*;
    localparam int unsigned CAL_LEN = 64;  // Shortened calibration
    localparam int LOAD = FUSE_LOAD_CYCLES;
    logic mclk, rst_n, hw_reset, ref_sel, cs_n, sclk, sdi, sdo, sdo_oe, busy, done;
    logic [7:0] rd;
    int errors = 0;
    int n_checks = 0;
    initial mclk = 1'b0;
    always #2.5 mclk = ~mclk;
    crs_init_sequencer #(.CAL_LEN(CAL_LEN)) i_dut (
        .mclk_i(mclk), .rst_n_i(rst_n), .hw_reset_i(hw_reset),
        .reference_select_pin_i(ref_sel), .serial_port_chip_select_n_i(cs_n),
        .serial_clk_i(sclk), .serial_data_i(sdi), .serial_data_o(sdo),
        .serial_data_oe_o(sdo_oe), .init_busy_o(busy), .cal_done_o(done));
    crs_host_model #(.PWR_DLY(40), .HP(6)) i_host (
        .mclk_i(mclk), .sdo_i(sdo), .hw_reset_o(hw_reset), .ref_sel_o(ref_sel),
        .cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi));
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish;
        $display("Checks %0d, errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : tally_and_finish
    // Cycles until calibration completes, bounded
    task automatic wait_done(output int n);
        n = 0;
        while (done !== 1'b1 && n < CAL_LEN + 100)
        begin
            @(negedge mclk);
            n++;
        end
        if (done !== 1'b1)
        begin
            errors++;
            tally_and_finish();
        end
    endtask : wait_done
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_power_up;
        int   n;
        logic in_win;
        i_host.pin_reset(1'b1);
        repeat (10) @(negedge mclk);
        check({6'h00, busy, done}, 8'h02);
        wait_done(n);
        in_win = (n + 10 >= CAL_LEN + LOAD) && (n + 10 <= CAL_LEN + LOAD + 8);
        check({7'h00, in_win}, 8'h01);
        i_host.frame(1'b1, INIT_STATUS_OFS, 8'h00, rd);
        check(rd, 8'h07);
    endtask : t_power_up
    task automatic t_soft_reset;
        int   n;
        logic in_win;
        i_host.frame(1'b0, SOFTWARE_RESET_CONTROL_OFS, 8'h01, rd);
        @(negedge mclk);
        check({6'h00, busy, done}, 8'h02);
        wait_done(n);
        in_win = (n >= CAL_LEN - 8) && (n <= CAL_LEN + LOAD);
        check({7'h00, in_win}, 8'h01);
        i_host.frame(1'b1, SOFTWARE_RESET_CONTROL_OFS, 8'h00, rd);
        check(rd, SOFTWARE_RESET_CONTROL_RST);
    endtask : t_soft_reset
    // Unmapped and read-only writes, and a control write without bit 0, change nothing
    task automatic t_refused;
        i_host.frame(1'b0, 15'h0002, 8'hff, rd);
        i_host.frame(1'b1, 15'h0002, 8'h00, rd);
        check(rd, UNMAPPED_READ);
        i_host.frame(1'b0, SOFTWARE_RESET_CONTROL_OFS, 8'hfe, rd);
        i_host.frame(1'b0, INIT_STATUS_OFS, 8'hff, rd);
        @(negedge mclk);
        check({6'h00, busy, done}, 8'h01);
        i_host.frame(1'b1, INIT_STATUS_OFS, 8'h00, rd);
        check(rd, 8'h07);
    endtask : t_refused
    task automatic t_pin_mid_cal;
        int   n;
        logic in_win;
        i_host.pin_reset(1'b1);
        repeat (10) @(negedge mclk);
        check({6'h00, busy, done}, 8'h02);
        i_host.pin_reset(1'b0);
        wait_done(n);
        in_win = (n >= CAL_LEN + LOAD) && (n <= CAL_LEN + LOAD + 8);
        check({7'h00, in_win}, 8'h01);
        i_host.frame(1'b1, INIT_STATUS_OFS, 8'h00, rd);
        check(rd, 8'h03);
    endtask : t_pin_mid_cal
    // Main sequence
    initial
    begin
        rst_n = 1'b0;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        t_power_up();
        t_soft_reset();
        t_refused();
        t_pin_mid_cal();
        tally_and_finish();
    end
endmodule : crs_init_sequencer_test
